/* rtl/eir_consts.vh */
// Constants for the external interrupt and transfer response block
`ifndef EIR_CONSTS_VH
`define EIR_CONSTS_VH

// ----------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------
`define EIR_OFF_IRQ_CTRL 7'h00
`define EIR_OFF_CC_MODE 7'h20
`define EIR_OFF_CC_CAPT 7'h30
`define EIR_OFF_AUX_A_CTRL 7'h40
`define EIR_OFF_AUX_B_CTRL 7'h41
`define EIR_OFF_CR_CTRL 7'h42
`define EIR_OFF_AUX_A_CAPT 7'h43
`define EIR_OFF_AUX_B_CAPT 7'h44
`define EIR_OFF_CR_CAPT 7'h45
`define EIR_OFF_PORT_DIR_LO 7'h46
`define EIR_OFF_PORT_DIR_HI 7'h47
`define EIR_OFF_TRAP_FLAG 7'h48
`define EIR_OFF_XFER_CNT 7'h50
`define EIR_OFF_STATUS 7'h58

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EIR_IC_FLAG 0
`define EIR_IC_EN 1
`define EIR_IC_XFER 2
`define EIR_IC_LVL_LO 3
`define EIR_IC_LVL_HI 6
`define EIR_IC_CH_LO 7
`define EIR_IC_CH_HI 9
`define EIR_AUX_MODE_LO 0
`define EIR_AUX_MODE_HI 2
`define EIR_AUX_EDGE_LO 3
`define EIR_AUX_EDGE_HI 4
`define EIR_CR_CAPEN 0
`define EIR_CR_EDGE_LO 1
`define EIR_CR_EDGE_HI 2

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define EIR_CC_CAP_RISE 3'h1
`define EIR_CC_CAP_FALL 3'h2
`define EIR_CC_CAP_BOTH 3'h3
`define EIR_AUX_CAPTURE 3'h5
`define EIR_DIR_RST 19'h0_0000
`define EIR_MODE_RST 3'h0
`define EIR_CNT_RST 8'h00
`define EIR_SRC_AUX_A 16
`define EIR_SRC_AUX_B 17
`define EIR_SRC_CR 18

// ----------------------------------------------------------------------
// Timing in states (one state is one clock)
// ----------------------------------------------------------------------
`define EIR_CYCLE_STATES 4'h2
`define EIR_HOLD_STATES 4'h1
`define EIR_ROM_STATES 4'h2
`define EIR_PSW_STATES 4'h2
`define EIR_ACK_DELAY_STATES 5'h02

`endif

/* rtl/eir_ext_irq_xfer.v */
// External interrupt inputs, prioritisation rounds and transfer start timing
//
// What this block does
// R1: One prioritisation round per instruction cycle
// R2: Transfer winner starts next cycle, flag cleared
// R3: Control-register read by N repeats round
// R4: Minimum response three or four states
// R5: Each pipeline hold adds one state
// R6: ROM operand or branch N adds two
// R7: Status read after flag change adds two
// R8: Internal-ROM worst case at most nine states
// R9: External operands everywhere: seven bus accesses
// R10: External code, internal operands: access plus two
// R11: Acknowledge delays next instruction two states plus
// R12: Nineteen pins usable as interrupt inputs
// R13: Edges request at source level and vector
// R14: Pin counts only when direction is input
// R15: Capture mode codes select rise, fall, both
// R16: Capture edge latches base timer always
// R17: Enabled capture edge gives transfer or interrupt
// R18: Auxiliary capture mode and edge codes
// R19: Auxiliary edge copies core timer, requests
// R20: Capture disabled: reload input only flags
// R21: Reload input edge codes, enabled request
// R22: Non-maskable falling edge raises trap, outranks interrupts but not transfers
// R23: Transfer count decrements, zero gives interrupt
// R24: Pins synchronised, edges from successive samples
`timescale 1ns/10ps
`default_nettype none
`include "eir_consts.vh"

module eir_ext_irq_xfer #(
  parameter NSRC = 19,
  parameter TW = 16,
  parameter CW = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [15:0] capcomp_pin,
  input wire aux_timer_a_input,
  input wire aux_timer_b_input,
  input wire capreload_input_pin,
  input wire nmi_n,
  input wire [TW-1:0] capcomp_base_timer_a,
  input wire [TW-1:0] capcomp_base_timer_b,
  input wire [15:0] capcomp_timer_sel,
  input wire [TW-1:0] core_timer,
  input wire [TW-1:0] timer_five,
  input wire pipe_hold_a,
  input wire pipe_hold_b,
  input wire pipe_rom_or_branch,
  input wire pipe_psw_hazard,
  input wire pipe_reads_xfer_ctrl,
  input wire [3:0] pipe_ext_states,
  input wire [3:0] xfer_ext_states,
  output reg cycle_start,
  output reg xfer_start,
  output reg [2:0] xfer_chan,
  output reg [4:0] xfer_src,
  output reg irq_req,
  output reg [4:0] irq_vector,
  output reg [3:0] irq_level,
  output reg trap_req,
  output reg cpu_hold
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function edge_hit;
    input rise;
    input fall;
    input [1:0] sel;
    begin
      edge_hit = (sel[0] & rise) | (sel[1] & fall);
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------
  localparam NPIN = 20;
  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] sync1_r;
  reg [NPIN-1:0] sync2_r;
  reg [NPIN-1:0] sync3_r;
  reg [NPIN-1:0] level_r;
  wire [NPIN-1:0] rise;
  wire [NPIN-1:0] fall;
  reg [1:0] prime_r;
  wire primed;

  assign pin_raw = {nmi_n, capreload_input_pin, aux_timer_b_input, aux_timer_a_input, capcomp_pin};
  // Edges count only once the stages hold real pin levels
  assign primed = &prime_r;
  assign rise = sync2_r & sync3_r & ~level_r & {NPIN{primed}}; // [R24]
  assign fall = ~sync2_r & ~sync3_r & level_r & {NPIN{primed}}; // [R24]

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_r <= {NPIN{1'b1}};
      sync2_r <= {NPIN{1'b1}};
      sync3_r <= {NPIN{1'b1}};
      level_r <= {NPIN{1'b1}};
      prime_r <= 2'h0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      prime_r <= prime_r + {1'b0, ~primed};
      if (primed) begin
        level_r <= (sync2_r & sync3_r) | (level_r & (sync2_r | sync3_r)); // [R24]
      end else begin
        level_r <= sync2_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // Configuration state
  // --------------------------------------------------------------------
  reg [NSRC-1:0] en_r;
  reg [NSRC-1:0] xf_r;
  reg [NSRC-1:0] flag_r;
  reg [NSRC-1:0] force_irq_r;
  reg [3:0] lvl_r [0:NSRC-1];
  reg [2:0] ch_r [0:NSRC-1];
  reg [2:0] cc_mode_r [0:15];
  reg [TW-1:0] cc_capt_r [0:15];
  reg [4:0] aux_a_ctrl_r;
  reg [4:0] aux_b_ctrl_r;
  reg [2:0] cr_ctrl_r;
  reg [TW-1:0] aux_a_capt_r;
  reg [TW-1:0] aux_b_capt_r;
  reg [TW-1:0] cr_capt_r;
  reg [NSRC-1:0] port_dir_r;
  reg trap_flag_r;
  reg [CW-1:0] cnt_r [0:7];

  // --------------------------------------------------------------------
  // Source events
  // --------------------------------------------------------------------
  reg [NSRC-1:0] hit;
  integer k;
  always @* begin
    hit = {NSRC{1'b0}};
    for (k = 0; k < 16; k = k + 1) begin
      if (cc_mode_r[k] == `EIR_CC_CAP_RISE || cc_mode_r[k] == `EIR_CC_CAP_FALL ||
          cc_mode_r[k] == `EIR_CC_CAP_BOTH) begin
        hit[k] = edge_hit(rise[k], fall[k], cc_mode_r[k][1:0]); // [R15]
      end
    end
    if (aux_a_ctrl_r[`EIR_AUX_MODE_HI:`EIR_AUX_MODE_LO] == `EIR_AUX_CAPTURE) begin
      hit[`EIR_SRC_AUX_A] = edge_hit(rise[16], fall[16],
                                     aux_a_ctrl_r[`EIR_AUX_EDGE_HI:`EIR_AUX_EDGE_LO]); // [R18]
    end
    if (aux_b_ctrl_r[`EIR_AUX_MODE_HI:`EIR_AUX_MODE_LO] == `EIR_AUX_CAPTURE) begin
      hit[`EIR_SRC_AUX_B] = edge_hit(rise[17], fall[17],
                                     aux_b_ctrl_r[`EIR_AUX_EDGE_HI:`EIR_AUX_EDGE_LO]); // [R18]
    end
    hit[`EIR_SRC_CR] = edge_hit(rise[18], fall[18], cr_ctrl_r[`EIR_CR_EDGE_HI:`EIR_CR_EDGE_LO]); // [R21]
    hit = hit & ~port_dir_r; // [R14] [R12]
  end

  // --------------------------------------------------------------------
  // Instruction cycle timing
  // --------------------------------------------------------------------
  reg [4:0] st_r;
  reg [4:0] len_r;
  wire [4:0] len_nxt;
  wire cyc_end;
  assign len_nxt = {1'b0, `EIR_CYCLE_STATES}
                 + (pipe_hold_a ? {1'b0, `EIR_HOLD_STATES} : 5'h00) // [R5]
                 + (pipe_hold_b ? {1'b0, `EIR_HOLD_STATES} : 5'h00) // [R5]
                 + (pipe_rom_or_branch ? {1'b0, `EIR_ROM_STATES} : 5'h00) // [R6]
                 + (pipe_psw_hazard ? {1'b0, `EIR_PSW_STATES} : 5'h00) // [R7] [R8]
                 + {1'b0, pipe_ext_states}; // [R9] [R10]
  assign cyc_end = (st_r == len_r - 5'h01);

  // --------------------------------------------------------------------
  // Prioritisation round
  // --------------------------------------------------------------------
  reg found;
  reg [4:0] best;
  reg [3:0] best_lvl;
  integer j;
  always @* begin
    found = 1'b0;
    best = 5'h00;
    best_lvl = 4'h0;
    for (j = 0; j < NSRC; j = j + 1) begin
      if (flag_r[j] && en_r[j] && (!found || lvl_r[j] > best_lvl)) begin // [R1] [R13]
        found = 1'b1;
        best = j[4:0];
        best_lvl = lvl_r[j];
      end
    end
  end

  wire best_xfer;
  assign best_xfer = xf_r[best] & ~force_irq_r[best];

  reg win_r;
  reg win_xfer_r;
  reg [4:0] win_src_r;
  reg [4:0] hold_cnt_r;

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  wire wr_ic = reg_wr && reg_addr < `EIR_OFF_IRQ_CTRL + NSRC;
  wire [4:0] ic_idx = reg_addr[4:0];
  wire [2:0] cnt_idx = reg_addr[2:0];
  wire [NSRC-1:0] sw_flag_wr = wr_ic ? ({{NSRC-1{1'b0}}, 1'b1} << ic_idx) : {NSRC{1'b0}};

  // Servicing clears the winner's flag at the start of the next cycle
  wire cycle_start_nxt_c = (st_r == 5'h00);
  wire serve = cycle_start_nxt_c && win_r;
  wire [NSRC-1:0] serve_clr = serve ? ({{NSRC-1{1'b0}}, 1'b1} << win_src_r) : {NSRC{1'b0}};
  wire [2:0] win_ch = ch_r[win_src_r];
  wire chain = serve && win_xfer_r && cnt_r[win_ch] == {{CW-1{1'b0}}, 1'b1};

  // --------------------------------------------------------------------
  // Main sequential logic
  // --------------------------------------------------------------------
  integer i;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      en_r <= {NSRC{1'b0}};
      xf_r <= {NSRC{1'b0}};
      flag_r <= {NSRC{1'b0}};
      force_irq_r <= {NSRC{1'b0}};
      for (i = 0; i < NSRC; i = i + 1) begin
        lvl_r[i] <= 4'h0;
        ch_r[i] <= 3'h0;
      end
      for (i = 0; i < 16; i = i + 1) begin
        cc_mode_r[i] <= `EIR_MODE_RST;
        cc_capt_r[i] <= {TW{1'b0}};
      end
      for (i = 0; i < 8; i = i + 1) begin
        cnt_r[i] <= `EIR_CNT_RST;
      end
      aux_a_ctrl_r <= 5'h00;
      aux_b_ctrl_r <= 5'h00;
      cr_ctrl_r <= 3'h0;
      aux_a_capt_r <= {TW{1'b0}};
      aux_b_capt_r <= {TW{1'b0}};
      cr_capt_r <= {TW{1'b0}};
      port_dir_r <= `EIR_DIR_RST;
      trap_flag_r <= 1'b0;
      st_r <= 5'h00;
      len_r <= {1'b0, `EIR_CYCLE_STATES};
      win_r <= 1'b0;
      win_xfer_r <= 1'b0;
      win_src_r <= 5'h00;
      hold_cnt_r <= 5'h00;
      cycle_start <= 1'b0;
      xfer_start <= 1'b0;
      xfer_chan <= 3'h0;
      xfer_src <= 5'h00;
      irq_req <= 1'b0;
      irq_vector <= 5'h00;
      irq_level <= 4'h0;
      trap_req <= 1'b0;
      cpu_hold <= 1'b0;
    end else begin
      // Software writes
      if (wr_ic) begin
        en_r[ic_idx] <= reg_wdata[`EIR_IC_EN];
        xf_r[ic_idx] <= reg_wdata[`EIR_IC_XFER];
        lvl_r[ic_idx] <= reg_wdata[`EIR_IC_LVL_HI:`EIR_IC_LVL_LO];
        ch_r[ic_idx] <= reg_wdata[`EIR_IC_CH_HI:`EIR_IC_CH_LO];
      end
      if (reg_wr && reg_addr[6:4] == 3'h2) begin
        cc_mode_r[reg_addr[3:0]] <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `EIR_OFF_AUX_A_CTRL) begin
        aux_a_ctrl_r <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `EIR_OFF_AUX_B_CTRL) begin
        aux_b_ctrl_r <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `EIR_OFF_CR_CTRL) begin
        cr_ctrl_r <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `EIR_OFF_PORT_DIR_LO) begin
        port_dir_r[15:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `EIR_OFF_PORT_DIR_HI) begin
        port_dir_r[NSRC-1:16] <= reg_wdata[NSRC-17:0];
      end

      // Request flags: hardware set wins over any clear
      for (i = 0; i < NSRC; i = i + 1) begin
        if (hit[i] || (chain && win_src_r == i[4:0])) begin
          flag_r[i] <= 1'b1; // [R13] [R17] [R20]
        end else if (sw_flag_wr[i]) begin
          flag_r[i] <= reg_wdata[`EIR_IC_FLAG];
        end else if (serve_clr[i]) begin
          flag_r[i] <= 1'b0; // [R2]
        end
      end
      if (chain) begin
        force_irq_r[win_src_r] <= 1'b1; // [R23]
      end else if (serve && !win_xfer_r) begin
        force_irq_r[win_src_r] <= 1'b0;
      end

      // Captures
      for (i = 0; i < 16; i = i + 1) begin
        if (hit[i]) begin
          cc_capt_r[i] <= capcomp_timer_sel[i] ? capcomp_base_timer_b : capcomp_base_timer_a; // [R16]
        end
      end
      if (hit[`EIR_SRC_AUX_A]) begin
        aux_a_capt_r <= core_timer; // [R19]
      end
      if (hit[`EIR_SRC_AUX_B]) begin
        aux_b_capt_r <= core_timer; // [R19]
      end
      if (hit[`EIR_SRC_CR] && cr_ctrl_r[`EIR_CR_CAPEN]) begin
        cr_capt_r <= timer_five; // [R20]
      end

      // Non-maskable trap
      if (fall[19]) begin
        trap_flag_r <= 1'b1; // [R22]
      end else if (reg_wr && reg_addr == `EIR_OFF_TRAP_FLAG && !reg_wdata[0]) begin
        trap_flag_r <= 1'b0;
      end
      trap_req <= trap_flag_r | fall[19]; // [R22]

      // Transfer counts: hardware decrement wins over a software write
      if (serve && win_xfer_r && cnt_r[win_ch] != {CW{1'b0}}) begin
        cnt_r[win_ch] <= cnt_r[win_ch] - {{CW-1{1'b0}}, 1'b1}; // [R23]
      end else if (reg_wr && reg_addr[6:3] == 4'hA) begin
        cnt_r[cnt_idx] <= reg_wdata[CW-1:0];
      end

      // Cycle counter
      cycle_start <= cyc_end;
      if (cyc_end) begin
        st_r <= 5'h00;
        len_r <= len_nxt;
      end else begin
        st_r <= st_r + 5'h01;
      end

      // Round at cycle end, service in the next cycle's first state
      if (cyc_end) begin
        if (found && best_xfer && pipe_reads_xfer_ctrl) begin
          win_r <= 1'b0; // [R3]
        end else if (found && !best_xfer && trap_flag_r) begin
          win_r <= 1'b0; // [R22]
        end else begin
          win_r <= found; // [R1]
        end
        win_xfer_r <= best_xfer;
        win_src_r <= best;
      end else if (serve) begin
        win_r <= 1'b0;
      end

      xfer_start <= serve && win_xfer_r; // [R2] [R4]
      irq_req <= serve && !win_xfer_r; // [R13]
      if (serve) begin
        xfer_chan <= win_ch;
        xfer_src <= win_src_r;
        irq_vector <= win_src_r;
        irq_level <= lvl_r[win_src_r];
      end

      // Instruction delay after acknowledge
      if (serve && win_xfer_r) begin
        hold_cnt_r <= `EIR_ACK_DELAY_STATES + {1'b0, xfer_ext_states}; // [R11]
        cpu_hold <= 1'b1;
      end else if (hold_cnt_r > 5'h01) begin
        hold_cnt_r <= hold_cnt_r - 5'h01;
        cpu_hold <= 1'b1;
      end else begin
        hold_cnt_r <= 5'h00;
        cpu_hold <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (reg_addr < `EIR_OFF_IRQ_CTRL + NSRC) begin
      rd_mux = {6'h00, ch_r[ic_idx], lvl_r[ic_idx], xf_r[ic_idx], en_r[ic_idx], flag_r[ic_idx]};
    end else if (reg_addr[6:4] == 3'h2) begin
      rd_mux = {13'h0000, cc_mode_r[reg_addr[3:0]]};
    end else if (reg_addr[6:4] == 3'h3) begin
      rd_mux = cc_capt_r[reg_addr[3:0]];
    end else if (reg_addr[6:3] == 4'hA) begin
      rd_mux = {{16-CW{1'b0}}, cnt_r[cnt_idx]};
    end else begin
      case (reg_addr)
        `EIR_OFF_AUX_A_CTRL: rd_mux = {11'h000, aux_a_ctrl_r};
        `EIR_OFF_AUX_B_CTRL: rd_mux = {11'h000, aux_b_ctrl_r};
        `EIR_OFF_CR_CTRL: rd_mux = {13'h0000, cr_ctrl_r};
        `EIR_OFF_AUX_A_CAPT: rd_mux = aux_a_capt_r;
        `EIR_OFF_AUX_B_CAPT: rd_mux = aux_b_capt_r;
        `EIR_OFF_CR_CAPT: rd_mux = cr_capt_r;
        `EIR_OFF_PORT_DIR_LO: rd_mux = port_dir_r[15:0];
        `EIR_OFF_PORT_DIR_HI: rd_mux = {13'h0000, port_dir_r[NSRC-1:16]};
        `EIR_OFF_TRAP_FLAG: rd_mux = {15'h0000, trap_flag_r};
        `EIR_OFF_STATUS: rd_mux = {cpu_hold, win_xfer_r, win_r, 8'h00, win_src_r};
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // eir_ext_irq_xfer
`default_nettype wire

/* tb/eir_ext_irq_xfer_sva.sv */
// Checker for the external interrupt and transfer response block
`timescale 1ns/10ps
`default_nettype none
module eir_ext_irq_xfer_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_rdata,
  input wire logic nmi_n,
  input wire logic cycle_start,
  input wire logic xfer_start,
  input wire logic irq_req,
  input wire logic trap_req,
  input wire logic cpu_hold
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ----
  // Assertions
  // ----
  a_cycle_gap: assert property (cycle_start |=> !cycle_start)
    else $error("instruction cycle shorter than two clocks");
  a_one_service: assert property ((xfer_start || irq_req) |=> !(xfer_start || irq_req))
    else $error("two services in one cycle");
  a_single_grant: assert property (!(xfer_start && irq_req))
    else $error("transfer and interrupt granted together");
  a_xfer_after_cycle: assert property (xfer_start |-> $past(cycle_start))
    else $error("transfer not one clock after cycle start");
  a_irq_after_cycle: assert property (irq_req |-> $past(cycle_start))
    else $error("interrupt not one clock after cycle start");
  a_hold_after_xfer: assert property (xfer_start |-> ##[0:1] cpu_hold ##1 cpu_hold)
    else $error("cpu hold shorter than two clocks");
  a_hold_cause: assert property ($rose(cpu_hold) |-> xfer_start || $past(xfer_start))
    else $error("cpu hold without transfer");
  a_nmi_trap: assert property ($fell(nmi_n) |-> ##[1:6] trap_req)
    else $error("falling edge gave no trap");
  a_trap_sticky: assert property (trap_req && !reg_wr && !$past(reg_wr) |=> trap_req)
    else $error("trap flag dropped without write");
  a_trap_first: assert property (trap_req && $past(trap_req, 2) |-> !irq_req)
    else $error("interrupt granted while trap pending");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  c_xfer_irq: cover property (xfer_start ##[1:200] irq_req);
  c_trap: cover property ($fell(nmi_n) ##[1:6] trap_req);
  c_hold: cover property (xfer_start ##1 cpu_hold [*2]);
endmodule // eir_ext_irq_xfer_chk

bind eir_ext_irq_xfer eir_ext_irq_xfer_chk u_chk (.sys_clk, .rst_n, .reg_rd, .reg_wr, .reg_rdata, .nmi_n,
  .cycle_start, .xfer_start, .irq_req, .trap_req, .cpu_hold);
`default_nettype wire

/* tb/eir_pin_src.sv */
// External signal sources driving the interrupt-capable pins
`timescale 1ns/10ps
`default_nettype none
module eir_pin_src (
  input wire logic sys_clk,
  output logic [15:0] capcomp_pin,
  output logic aux_timer_a_input,
  output logic aux_timer_b_input,
  output logic capreload_input_pin,
  output logic nmi_n
);
  // Index 19 is the non-maskable line, idle high
  logic [19:0] lvl_r = 20'h8_0000;
  assign capcomp_pin = lvl_r[15:0];
  assign aux_timer_a_input = lvl_r[16];
  assign aux_timer_b_input = lvl_r[17];
  assign capreload_input_pin = lvl_r[18];
  assign nmi_n = lvl_r[19];
  // Level held for hold clocks, slow or prompt
  task automatic drive(input int idx, input logic v, input int hold);
    @(posedge sys_clk);
    lvl_r[idx] <= v;
    repeat (hold) @(posedge sys_clk);
  endtask
endmodule // eir_pin_src
`default_nettype wire

/* tb/ext_irq_and_xfer_response_bench.sv */
// Self-checking bench for the external interrupt and transfer response block
`timescale 1ns/10ps
`default_nettype none
`include "eir_consts.vh"
module ext_irq_and_xfer_response_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rnd_on = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000, capcomp_timer_sel = 16'h0000, core_timer = 16'h0000;
  logic [15:0] capcomp_base_timer_a = 16'h0000, capcomp_base_timer_b = 16'h0000, timer_five = 16'h0000;
  logic pipe_hold_a = 1'b0, pipe_hold_b = 1'b0, pipe_rom_or_branch = 1'b0;
  logic pipe_psw_hazard = 1'b0, pipe_reads_xfer_ctrl = 1'b0;
  logic [3:0] pipe_ext_states = 4'h0, xfer_ext_states = 4'h0;
  wire logic [15:0] capcomp_pin, reg_rdata;
  wire logic aux_timer_a_input, aux_timer_b_input, capreload_input_pin, nmi_n;
  wire logic cycle_start, xfer_start, irq_req, trap_req, cpu_hold;
  wire logic [2:0] xfer_chan;
  wire logic [4:0] xfer_src, irq_vector;
  wire logic [3:0] irq_level;
  int errors = 0, n_tests = 0, n_xfer = 0, n_irq = 0, cyc = 0;

  eir_pin_src src (.sys_clk, .capcomp_pin, .aux_timer_a_input, .aux_timer_b_input, .capreload_input_pin, .nmi_n);
  eir_ext_irq_xfer DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .capcomp_pin,
    .aux_timer_a_input, .aux_timer_b_input, .capreload_input_pin, .nmi_n, .capcomp_base_timer_a,
    .capcomp_base_timer_b, .capcomp_timer_sel, .core_timer, .timer_five, .pipe_hold_a, .pipe_hold_b,
    .pipe_rom_or_branch, .pipe_psw_hazard, .pipe_reads_xfer_ctrl, .pipe_ext_states, .xfer_ext_states,
    .cycle_start, .xfer_start, .xfer_chan, .xfer_src, .irq_req, .irq_vector, .irq_level, .trap_req, .cpu_hold);

  // ----
  // Clock, grant counters, pipeline hazards, timeout
  // ----
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (xfer_start === 1'b1) n_xfer <= n_xfer + 1;
    if (irq_req === 1'b1) n_irq <= n_irq + 1;
    {pipe_hold_a, pipe_hold_b, pipe_rom_or_branch, pipe_psw_hazard, pipe_reads_xfer_ctrl} <= rnd_on ? 5'($urandom) : 5'h00;
    pipe_ext_states <= rnd_on ? 4'($urandom_range(2, 0)) : 4'h0;
    xfer_ext_states <= rnd_on ? 4'($urandom_range(3, 0)) : 4'h0;
    if (cyc == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk("register", d, exp);
  endtask
  // Edge code k into the control of source s
  task automatic cfg(input int s, input logic [2:0] k);
    if (s < 16) wr(`EIR_OFF_CC_MODE + 7'(s), {13'h0, k});
    else if (s < 18) wr(`EIR_OFF_AUX_A_CTRL + 7'(s - 16), {11'h0, k[1:0], `EIR_AUX_CAPTURE});
    else wr(`EIR_OFF_CR_CTRL, {13'h0, k[1:0], 1'b0});
  endtask
  function automatic logic hit(input logic [2:0] k, input logic rise);
    return rise ? k[0] : k[1];
  endfunction
  task automatic edges(input int s, input logic [2:0] k);
    cfg(s, k);
    for (int v = 1; v >= 0; v--) begin
      src.drive(s, v[0], $urandom_range(12, 6));
      rdchk(`EIR_OFF_IRQ_CTRL + 7'(s), {15'h0, hit(k, v[0])});
      wr(`EIR_OFF_IRQ_CTRL + 7'(s), 16'h0000);
    end
    if (s < 16) rdchk(`EIR_OFF_CC_CAPT + 7'(s), capcomp_timer_sel[s] ? capcomp_base_timer_b : capcomp_base_timer_a);
    else if (s < 18) rdchk(`EIR_OFF_AUX_A_CAPT + 7'(s - 16), core_timer);
    else rdchk(`EIR_OFF_CR_CAPT, 16'h0000);
    cfg(s, 3'h0);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    int s, c, cnt, nx, ni;
    logic [3:0] lv;
    void'($urandom(32'h08c0));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    capcomp_base_timer_a <= 16'($urandom);
    capcomp_base_timer_b <= 16'($urandom);
    core_timer <= 16'($urandom);
    timer_five <= 16'($urandom);
    capcomp_timer_sel <= 16'($urandom);
    rdchk(`EIR_OFF_PORT_DIR_LO, 16'h0000);
    rdchk(`EIR_OFF_CC_MODE, 16'h0000);
    rdchk(`EIR_OFF_XFER_CNT, 16'h0000);
    rdchk(7'h7F, 16'h0000);
    for (int i = 0; i < 4; i++)
      for (int k = 1; k < 4; k++) edges(i == 0 ? $urandom_range(15, 0) : 15 + i, 3'(k));
    // Pin set to output, and auxiliary timer outside capture mode
    s = $urandom_range(15, 0);
    cfg(s, 3'h3);
    wr(`EIR_OFF_PORT_DIR_LO, 16'(1 << s));
    src.drive(s, 1'b1, 6);
    rdchk(`EIR_OFF_IRQ_CTRL + 7'(s), 16'h0000);
    src.drive(s, 1'b0, 6);
    wr(`EIR_OFF_PORT_DIR_LO, 16'h0000);
    cfg(s, 3'h0);
    wr(`EIR_OFF_AUX_A_CTRL, 16'h0018);
    src.drive(16, 1'b1, 6);
    rdchk(`EIR_OFF_IRQ_CTRL + 7'd16, 16'h0000);
    src.drive(16, 1'b0, 6);
    // Transfers, count reaching zero, random pipeline hazards
    for (int j = 0; j < 6; j++) begin
      s = $urandom_range(18, 0);
      c = $urandom_range(7, 0);
      cnt = (j % 2) ? 3 : 1;
      lv = 4'($urandom_range(15, 1));
      cfg(s, 3'h3);
      wr(`EIR_OFF_XFER_CNT + 7'(c), 16'(cnt));
      wr(`EIR_OFF_IRQ_CTRL + 7'(s), {6'h00, 3'(c), lv, 3'b110});
      nx = n_xfer;
      ni = n_irq;
      rnd_on <= (j >= 2);
      src.drive(s, ~src.lvl_r[s], 6);
      for (int w = 0; w < 100 && n_xfer == nx; w++) @(posedge sys_clk);
      for (int w = 0; w < 100 && n_irq == ni && cnt == 1; w++) @(posedge sys_clk);
      rnd_on <= 1'b0;
      repeat (12) @(posedge sys_clk);
      chk("transfers", n_xfer - nx, 1);
      chk("channel", xfer_chan, c);
      chk("source", xfer_src, s);
      rdchk(`EIR_OFF_XFER_CNT + 7'(c), 16'(cnt - 1));
      rdchk(`EIR_OFF_IRQ_CTRL + 7'(s), {6'h00, 3'(c), lv, 3'b110});
      chk("interrupts", n_irq - ni, cnt == 1);
      if (cnt == 1) chk("vector", {irq_level, irq_vector}, {lv, 5'(s)});
      wr(`EIR_OFF_IRQ_CTRL + 7'(s), 16'h0000);
      cfg(s, 3'h0);
    end
    // Trap outranks a pending interrupt
    src.drive(19, 1'b0, 6);
    chk("trap", trap_req, 1'b1);
    rdchk(`EIR_OFF_TRAP_FLAG, 16'h0001);
    s = $urandom_range(15, 0);
    cfg(s, 3'h3);
    wr(`EIR_OFF_IRQ_CTRL + 7'(s), 16'h004A);
    ni = n_irq;
    src.drive(s, ~src.lvl_r[s], 20);
    chk("masked by trap", n_irq - ni, 0);
    wr(`EIR_OFF_IRQ_CTRL + 7'(s), 16'h0000);
    wr(`EIR_OFF_TRAP_FLAG, 16'h0000);
    src.drive(19, 1'b1, 8);
    chk("trap cleared", trap_req, 1'b0);
    report_and_stop();
  end
endmodule // ext_irq_and_xfer_response_bench
`default_nettype wire
